// ---- psf_defs.svh ----
// constants for the program status flag block
`ifndef PSF_DEFS_SVH
`define PSF_DEFS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define PSF_STATUS_OFFSET   8'hD0
`define PSF_STATUS_RESET    8'h00
`define PSF_WRITE_MASK      8'hFE
`define PSF_RDATA_PAD       24'h000000

// ----------------------------------------------------------------
// status word bit positions
// ----------------------------------------------------------------
`define PSF_CARRY_BIT       3'd7
`define PSF_NIBBLE_BIT      3'd6
`define PSF_USER0_BIT       3'd5
`define PSF_BANK_HI_BIT     3'd4
`define PSF_BANK_LO_BIT     3'd3
`define PSF_WRAP_BIT        3'd2
`define PSF_USER1_BIT       3'd1
`define PSF_PARITY_BIT      3'd0

// ----------------------------------------------------------------
// arithmetic limits
// ----------------------------------------------------------------
`define PSF_PRODUCT_LIMIT   16'h00FF
`define PSF_BCD_DIGIT_MAX   4'h9
`define PSF_BCD_LOW_ADJ     9'h006
`define PSF_BCD_HIGH_ADJ    9'h060

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define PSF_RESP_OKAY       2'b00
`define PSF_RESP_SLVERR     2'b10

`endif

// ---- psf_pkg.sv ----
// types shared by the program status flag block
package psf_pkg;

	// ------------------------------------------------------------
	// operations reported by the execution datapath
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		PSF_OP_NONE         = 4'h0,
		PSF_OP_ADD          = 4'h1,
		PSF_OP_ADDC         = 4'h2,
		PSF_OP_SUBB         = 4'h3,
		PSF_OP_PRODUCT      = 4'h4,
		PSF_OP_DIVIDE       = 4'h5,
		PSF_OP_BCD_ADJUST   = 4'h6,
		PSF_OP_COMPARE_JUMP = 4'h7,
		PSF_OP_ROT_RIGHT    = 4'h8,
		PSF_OP_ROT_LEFT     = 4'h9,
		PSF_OP_CARRY_CLR    = 4'hA,
		PSF_OP_CARRY_SET    = 4'hB,
		PSF_OP_CARRY_INV    = 4'hC,
		PSF_OP_CARRY_LOAD   = 4'hD
	} psf_op_type;

	// one executed instruction, valid for one cycle
	typedef struct packed {
		logic       valid;
		psf_op_type op;
		logic [7:0] opa;
		logic [7:0] opb;
		logic       bit_val;
	} psf_exec_type;

	// direct special function register write from the core
	typedef struct packed {
		logic       byte_we;
		logic       bit_we;
		logic [2:0] bit_idx;
		logic       bit_val;
		logic [7:0] wdata;
	} psf_sfr_wr_type;

	// ------------------------------------------------------------
	// bus state machines
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PSF_WR_IDLE = 2'b01,
		PSF_WR_RESP = 2'b10
	} psf_wr_state_type;

	typedef enum logic [1:0] {
		PSF_RD_IDLE = 2'b01,
		PSF_RD_DATA = 2'b10
	} psf_rd_state_type;

endpackage

// ---- psf_program_status_flags.sv ----
// program status word flag logic with core and axi4-lite access
//
// Functional notes
// RULE_01: add or subtract sets carry on msb carry-out or borrow, else clears.
// RULE_02: multiply and divide always force the carry flag to zero.
// RULE_03: bcd adjust updates carry when the packed bcd sum overflows.
// RULE_04: compare-jump sets carry when first unsigned operand is below second.
// RULE_05: nibble carry follows carry or borrow at bit 3, else cleared.
// RULE_06: user flag changes only by software writes, never by results.
// RULE_07: upper bank select sits at bit 4, software read and write.
// RULE_08: status word lives at address D0H and resets to all zeros.
// RULE_09: every status bit is reachable by bit access and byte access; parity bit 0 here takes neither write.
// RULE_10: the two bank bits choose one of four working register banks.
// RULE_11: parity tracks odd count of ones in accumulator, not writable.
// RULE_12: overflow from carries of bits 6 and 7; product above 255.
// RULE_13: explicit write wins over a same-cycle flag update.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "psf_defs.svh"

module psf_program_status_flags
	import psf_pkg::*;
(
	// clock and reset
	input  wire logic           ref_clk,
	input  wire logic           rst,
	// core execution datapath
	input  wire psf_exec_type   exec_in,
	input  wire psf_sfr_wr_type sfr_wr,
	input  wire logic [7:0]     acc_value,
	// status toward the core
	output logic [7:0]          status_word_q,
	output logic [7:0]          bank_base_q,
	// axi4-lite write channels
	input  wire logic [7:0]     s_axi_awaddr,
	input  wire logic           s_axi_awvalid,
	output logic                s_axi_awready,
	input  wire logic [31:0]    s_axi_wdata,
	input  wire logic [3:0]     s_axi_wstrb,
	input  wire logic           s_axi_wvalid,
	output logic                s_axi_wready,
	output logic [1:0]          s_axi_bresp,
	output logic                s_axi_bvalid,
	input  wire logic           s_axi_bready,
	// axi4-lite read channels
	input  wire logic [7:0]     s_axi_araddr,
	input  wire logic           s_axi_arvalid,
	output logic                s_axi_arready,
	output logic [31:0]         s_axi_rdata,
	output logic [1:0]          s_axi_rresp,
	output logic                s_axi_rvalid,
	input  wire logic           s_axi_rready
);

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------
	// word aligned match on the status word, low two bits ignored
	function automatic logic psf_hit(input logic [7:0] addr);
		psf_hit = (addr[7:2] == 6'(`PSF_STATUS_OFFSET >> 2)); // [RULE_08]
	endfunction

	// merge a software byte into the writable bits only
	function automatic logic [7:0] psf_merge(input logic [7:0] cur, wr);
		psf_merge = (cur & ~`PSF_WRITE_MASK) | (wr & `PSF_WRITE_MASK);
	endfunction

	// flag effect of one executed instruction on the status word
	function automatic logic [7:0] psf_apply(input logic [7:0] w,
		input psf_exec_type e);
		logic [7:0]  r;
		logic        cin;
		logic [8:0]  full, adj;
		logic [4:0]  nib;
		logic [7:0]  low7;
		logic [15:0] prod;
		r    = w;
		cin  = 1'b0;
		full = 9'h000;
		nib  = 5'h00;
		low7 = 8'h00;
		prod = 16'h0000;
		adj  = 9'h000;
		// user flags and bank bits are never touched here [RULE_06]
		case (e.op)
			PSF_OP_ADD, PSF_OP_ADDC: begin
				cin  = (e.op == PSF_OP_ADDC) ? w[`PSF_CARRY_BIT] : 1'b0;
				full = {1'b0, e.opa} + {1'b0, e.opb} + {8'h00, cin};
				nib  = {1'b0, e.opa[3:0]} + {1'b0, e.opb[3:0]}
					+ {4'h0, cin};
				low7 = {1'b0, e.opa[6:0]} + {1'b0, e.opb[6:0]}
					+ {7'h00, cin};
				r[`PSF_CARRY_BIT]  = full[8];           // [RULE_01]
				r[`PSF_NIBBLE_BIT] = nib[4];            // [RULE_05]
				r[`PSF_WRAP_BIT]   = full[8] ^ low7[7]; // [RULE_12]
			end
			PSF_OP_SUBB: begin
				cin  = w[`PSF_CARRY_BIT];
				full = {1'b0, e.opa} - {1'b0, e.opb} - {8'h00, cin};
				nib  = {1'b0, e.opa[3:0]} - {1'b0, e.opb[3:0]}
					- {4'h0, cin};
				low7 = {1'b0, e.opa[6:0]} - {1'b0, e.opb[6:0]}
					- {7'h00, cin};
				// borrow shows as the wrapped top bit of each difference
				r[`PSF_CARRY_BIT]  = full[8];           // [RULE_01]
				r[`PSF_NIBBLE_BIT] = nib[4];            // [RULE_05]
				r[`PSF_WRAP_BIT]   = full[8] ^ low7[7]; // [RULE_12]
			end
			PSF_OP_PRODUCT: begin
				prod = {8'h00, e.opa} * {8'h00, e.opb};
				r[`PSF_CARRY_BIT] = 1'b0;                       // [RULE_02]
				r[`PSF_WRAP_BIT]  = (prod > `PSF_PRODUCT_LIMIT); // [RULE_12]
			end
			PSF_OP_DIVIDE: begin
				// a zero divisor leaves the quotient undefined
				r[`PSF_CARRY_BIT] = 1'b0;          // [RULE_02]
				r[`PSF_WRAP_BIT]  = (e.opb == 8'h00);
			end
			PSF_OP_BCD_ADJUST: begin
				adj = {1'b0, e.opa};
				if (adj[3:0] > `PSF_BCD_DIGIT_MAX || w[`PSF_NIBBLE_BIT])
					adj = adj + `PSF_BCD_LOW_ADJ;
				if (adj[7:4] > `PSF_BCD_DIGIT_MAX || adj[8]
					|| w[`PSF_CARRY_BIT])
					adj = adj + `PSF_BCD_HIGH_ADJ;
				// carry is only ever set here, never cleared
				r[`PSF_CARRY_BIT] = w[`PSF_CARRY_BIT] | adj[8]; // [RULE_03]
			end
			PSF_OP_COMPARE_JUMP: begin
				r[`PSF_CARRY_BIT] = (e.opa < e.opb); // [RULE_04]
			end
			PSF_OP_ROT_RIGHT:  r[`PSF_CARRY_BIT] = e.opa[0];
			PSF_OP_ROT_LEFT:   r[`PSF_CARRY_BIT] = e.opa[7];
			PSF_OP_CARRY_CLR:  r[`PSF_CARRY_BIT] = 1'b0;
			PSF_OP_CARRY_SET:  r[`PSF_CARRY_BIT] = 1'b1;
			PSF_OP_CARRY_INV:  r[`PSF_CARRY_BIT] = ~w[`PSF_CARRY_BIT];
			// logic and move results on carry come in computed
			PSF_OP_CARRY_LOAD: r[`PSF_CARRY_BIT] = e.bit_val;
			default:           r = w;
		endcase
		psf_apply = r;
	endfunction

	// ------------------------------------------------------------
	// state declarations
	// ------------------------------------------------------------
	logic [7:0]       psw_q, psw_d;
	logic [7:0]       bank_base_d;
	psf_wr_state_type wr_state_q, wr_state_d;
	logic             aw_got_q, aw_got_d;
	logic             w_got_q, w_got_d;
	logic [7:0]       wr_addr_q, wr_addr_d;
	logic [7:0]       wr_byte_q, wr_byte_d;
	logic             wr_lane_q, wr_lane_d;
	logic             awready_d, wready_d;
	logic             bvalid_d;
	logic [1:0]       bresp_d;
	logic             wr_commit;
	psf_rd_state_type rd_state_q, rd_state_d;
	logic             arready_d, rvalid_d;
	logic [31:0]      rdata_d;
	logic [1:0]       rresp_d;

	// ------------------------------------------------------------
	// write channels: address and data taken in either order
	// ------------------------------------------------------------
	always_comb begin
		wr_state_d = wr_state_q;
		aw_got_d   = aw_got_q;
		w_got_d    = w_got_q;
		wr_addr_d  = wr_addr_q;
		wr_byte_d  = wr_byte_q;
		wr_lane_d  = wr_lane_q;
		awready_d  = s_axi_awready;
		wready_d   = s_axi_wready;
		bvalid_d   = s_axi_bvalid;
		bresp_d    = s_axi_bresp;
		wr_commit  = 1'b0;
		case (wr_state_q)
			PSF_WR_IDLE: begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_got_d  = 1'b1;
					wr_addr_d = s_axi_awaddr;
					awready_d = 1'b0;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_got_d   = 1'b1;
					wr_byte_d = s_axi_wdata[7:0];
					wr_lane_d = s_axi_wstrb[0];
					wready_d  = 1'b0;
				end
				// commit in the cycle the second half arrives
				if (aw_got_d && w_got_d) begin
					wr_commit  = psf_hit(wr_addr_d) & wr_lane_d;
					bvalid_d   = 1'b1;
					bresp_d    = psf_hit(wr_addr_d) ? `PSF_RESP_OKAY
						: `PSF_RESP_SLVERR;
					wr_state_d = PSF_WR_RESP;
				end
			end
			PSF_WR_RESP: begin
				if (s_axi_bready) begin
					bvalid_d   = 1'b0;
					aw_got_d   = 1'b0;
					w_got_d    = 1'b0;
					awready_d  = 1'b1;
					wready_d   = 1'b1;
					wr_state_d = PSF_WR_IDLE;
				end
			end
			default: begin
				wr_state_d = PSF_WR_IDLE;
				aw_got_d   = 1'b0;
				w_got_d    = 1'b0;
				awready_d  = 1'b1;
				wready_d   = 1'b1;
				bvalid_d   = 1'b0;
			end
		endcase
	end

	// write channel registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_state_q    <= PSF_WR_IDLE;
			aw_got_q      <= 1'b0;
			w_got_q       <= 1'b0;
			wr_addr_q     <= 8'h00;
			wr_byte_q     <= 8'h00;
			wr_lane_q     <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PSF_RESP_OKAY;
		end else begin
			wr_state_q    <= wr_state_d;
			aw_got_q      <= aw_got_d;
			w_got_q       <= w_got_d;
			wr_addr_q     <= wr_addr_d;
			wr_byte_q     <= wr_byte_d;
			wr_lane_q     <= wr_lane_d;
			s_axi_awready <= awready_d;
			s_axi_wready  <= wready_d;
			s_axi_bvalid  <= bvalid_d;
			s_axi_bresp   <= bresp_d;
		end
	end

	// ------------------------------------------------------------
	// read channels: one beat answered the cycle after the address
	// ------------------------------------------------------------
	always_comb begin
		rd_state_d = rd_state_q;
		arready_d  = s_axi_arready;
		rvalid_d   = s_axi_rvalid;
		rdata_d    = s_axi_rdata;
		rresp_d    = s_axi_rresp;
		case (rd_state_q)
			PSF_RD_IDLE: begin
				if (s_axi_arvalid && s_axi_arready) begin
					// unmapped reads return zero with an error
					rdata_d    = psf_hit(s_axi_araddr)
						? {`PSF_RDATA_PAD, psw_q} : 32'h00000000;
					rresp_d    = psf_hit(s_axi_araddr) ? `PSF_RESP_OKAY
						: `PSF_RESP_SLVERR;
					rvalid_d   = 1'b1;
					arready_d  = 1'b0;
					rd_state_d = PSF_RD_DATA;
				end
			end
			PSF_RD_DATA: begin
				if (s_axi_rready) begin
					rvalid_d   = 1'b0;
					arready_d  = 1'b1;
					rd_state_d = PSF_RD_IDLE;
				end
			end
			default: begin
				rvalid_d   = 1'b0;
				arready_d  = 1'b1;
				rd_state_d = PSF_RD_IDLE;
			end
		endcase
	end

	// read channel registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_state_q    <= PSF_RD_IDLE;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `PSF_RESP_OKAY;
		end else begin
			rd_state_q    <= rd_state_d;
			s_axi_arready <= arready_d;
			s_axi_rvalid  <= rvalid_d;
			s_axi_rdata   <= rdata_d;
			s_axi_rresp   <= rresp_d;
		end
	end

	// ------------------------------------------------------------
	// status word: flag update, then explicit writes on top
	// ------------------------------------------------------------
	always_comb begin
		psw_d = psw_q;
		if (exec_in.valid)
			psw_d = psf_apply(psw_q, exec_in);
		// explicit writes are applied last so they take precedence
		if (sfr_wr.byte_we)
			psw_d = psf_merge(psw_d, sfr_wr.wdata); // [RULE_13] [RULE_07]
		if (sfr_wr.bit_we && sfr_wr.bit_idx != `PSF_PARITY_BIT)
			psw_d[sfr_wr.bit_idx] = sfr_wr.bit_val; // [RULE_09] [RULE_13]
		// the byte of this write only, never a stale earlier one
		if (wr_commit)
			psw_d = psf_merge(psw_d, wr_byte_d); // [RULE_13]
		// parity always follows the accumulator, writes are dropped
		psw_d[`PSF_PARITY_BIT] = ^acc_value; // [RULE_11]
		// bank base is the address of r0 in internal ram
		bank_base_d = {3'b000, psw_d[`PSF_BANK_HI_BIT],
			psw_d[`PSF_BANK_LO_BIT], 3'b000}; // [RULE_10]
	end

	// status word registers, cleared on reset
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			psw_q         <= `PSF_STATUS_RESET; // [RULE_08]
			status_word_q <= `PSF_STATUS_RESET;
			bank_base_q   <= 8'h00;
		end else begin
			psw_q         <= psw_d;
			status_word_q <= psw_d;
			bank_base_q   <= bank_base_d;
		end
	end

endmodule

// ---- psf_status_checker.sv ----
// assertion checker for the status word flag block
`timescale 1ns/100ps

module psf_status_checker
	import psf_pkg::*;
(
	// clock and reset
	input logic           ref_clk,
	input logic           rst,
	// core side
	input psf_exec_type   exec_in,
	input psf_sfr_wr_type sfr_wr,
	input logic [7:0]     acc_value,
	input logic [7:0]     status_word_q,
	input logic [7:0]     bank_base_q,
	// bus side
	input logic           s_axi_awvalid,
	input logic           s_axi_wvalid,
	input logic [7:0]     s_axi_araddr,
	input logic           s_axi_arvalid,
	input logic           s_axi_arready,
	input logic [31:0]    s_axi_rdata,
	input logic [1:0]     s_axi_rresp,
	input logic           s_axi_rvalid
);
	// ------------------------------------------------------------
	// helper terms
	// ------------------------------------------------------------
	// no bus write in flight, so a core write is the last word
	wire       no_bus = !s_axi_awvalid && !s_axi_wvalid;
	// exec alone: flags are the only source of change
	wire       quiet  = exec_in.valid && !sfr_wr.byte_we
		&& !sfr_wr.bit_we && no_bus;
	wire       bw     = sfr_wr.byte_we && !sfr_wr.bit_we && no_bus;
	wire       tw     = sfr_wr.bit_we && no_bus;
	wire [8:0] sum9   = exec_in.opa + exec_in.opb;
	wire [4:0] sum5   = exec_in.opa[3:0] + exec_in.opb[3:0];
	wire       lt     = exec_in.opa < exec_in.opb;
	wire       par    = ^acc_value;
	wire       is_add = exec_in.op == PSF_OP_ADD;

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence rd_good;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'hD0;
	endsequence
	sequence rd_bad;
		s_axi_arvalid && s_axi_arready && s_axi_araddr != 8'hD0;
	endsequence

	add_carry_a: assert property (quiet && is_add |=>
		status_word_q[7] == $past(sum9[8])) else $error("add carry wrong");
	prod_carry_a: assert property (quiet && (exec_in.op == PSF_OP_PRODUCT
		|| exec_in.op == PSF_OP_DIVIDE) |=> !status_word_q[7])
		else $error("carry not forced low");
	cmp_carry_a: assert property (quiet && exec_in.op == PSF_OP_COMPARE_JUMP
		|=> status_word_q[7] == $past(lt)) else $error("compare carry wrong");
	nibble_add_a: assert property (quiet && is_add |=>
		status_word_q[6] == $past(sum5[4])) else $error("nibble carry wrong");
	user_keep_a: assert property (quiet |=>
		$stable({status_word_q[5:3], status_word_q[1]}))
		else $error("user bits changed by exec");
	bank_map_a: assert property (bank_base_q ==
		{3'b000, status_word_q[4:3], 3'b000}) else $error("bank base wrong");
	parity_lag_a: assert property (!$past(rst) |->
		status_word_q[0] == $past(par)) else $error("parity wrong");
	reset_zero_a: assert property (disable iff (1'b0) rst |->
		status_word_q == 8'h00 && bank_base_q == 8'h00)
		else $error("reset value wrong");
	byte_wins_a: assert property (bw |=>
		status_word_q[7:1] == $past(sfr_wr.wdata[7:1]))
		else $error("byte write lost");
	bit_write_a: assert property (tw && sfr_wr.bit_idx != 3'd0 |=>
		status_word_q[$past(sfr_wr.bit_idx)] == $past(sfr_wr.bit_val))
		else $error("bit write lost");
	read_word_a: assert property (rd_good |=> s_axi_rvalid
		&& s_axi_rresp == 2'b00 && s_axi_rdata == {24'h000000,
		$past(status_word_q)}) else $error("read data wrong");
	read_bad_a: assert property (rd_bad |=> s_axi_rvalid
		&& s_axi_rresp == 2'b10) else $error("unmapped read accepted");
endmodule

// ---- psf_core_model.sv ----
// execution datapath model driving the flag block's core side
`timescale 1ns/100ps

module psf_core_model
	import psf_pkg::*;
(
	// clock
	input  logic           ref_clk,
	// toward the flag block
	output psf_exec_type   exec_in,
	output psf_sfr_wr_type sfr_wr,
	output logic [7:0]     acc_value
);
	// idle until the bench asks for an instruction
	initial begin
		exec_in = '0;
		sfr_wr = '0;
		acc_value = 8'h00;
	end

	// one-cycle pulse; returns once the result has landed
	task automatic step(input psf_exec_type e, input psf_sfr_wr_type w);
		@(posedge ref_clk);
		exec_in <= e;
		sfr_wr <= w;
		@(posedge ref_clk);
		exec_in <= '0;
		sfr_wr <= '0;
		#1;
	endtask

	// parity lags a cycle, so wait one extra edge
	task automatic set_acc(input logic [7:0] v);
		@(posedge ref_clk);
		acc_value <= v;
		@(posedge ref_clk);
		@(posedge ref_clk);
		#1;
	endtask
endmodule

// ---- tb_top.sv ----
// self-checking bench for the status word flag block
`timescale 1ns/100ps

module tb_top
	import psf_pkg::*;
;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic           ref_clk = 1'b0;
	logic           rst;
	psf_exec_type   exec_in;
	psf_sfr_wr_type sfr_wr;
	logic [7:0]     acc_value, status_word_q, bank_base_q;
	logic [7:0]     s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]    s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0]     s_axi_wstrb = 4'h0;
	logic           s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic           s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic           s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic           s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]     s_axi_bresp, s_axi_rresp, rs;
	logic [7:0]     ex;
	int             err_total = 0, n_compared = 0;
	// {bit_val, op, first, second, expected flags} on a 3A preset
	logic [31:0]    rows [20] = '{
		32'h01FF01C0, 32'h017F0144, 32'h028888C4, 32'h030001C0,
		32'h03800144, 32'h04101004, 32'h040F1100, 32'h05100004,
		32'h05100200, 32'h069A0080, 32'h06450000, 32'h07010280,
		32'h07020100, 32'h08010080, 32'h09800080, 32'h0B000080,
		32'h0A000000, 32'h0C000080, 32'h1D000080, 32'h00FF0100};

	// free-running core clock, 8 ns
	always #4 ref_clk = ~ref_clk;

	psf_program_status_flags uut (.ref_clk, .rst, .exec_in, .sfr_wr,
		.acc_value, .status_word_q, .bank_base_q, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	psf_core_model core (.ref_clk, .exec_in, .sfr_wr, .acc_value);

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [33:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		// a real rising edge, so the asynchronous reset fires at once
		rst <= 1'b1;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		chk("reset", {status_word_q, bank_base_q}, 34'h0);
		ex = {3'b000, s_axi_awready, s_axi_wready, s_axi_arready,
			s_axi_bvalid, s_axi_rvalid};
		chk("idle bus", ex, 34'h1C);
		core.set_acc(8'h07);
		// preset user and bank bits, then run one instruction
		foreach (rows[i]) begin
			core.step('0, '{1'b1, 1'b0, 3'd0, 1'b0, 8'h3A});
			core.step('{1'b1, psf_op_type'(rows[i][27:24]),
				rows[i][23:16], rows[i][15:8], rows[i][28]}, '0);
			chk("row", status_word_q, rows[i][7:0] | 8'h3B);
		end
		chk("bank", bank_base_q, 8'h18);
		axi_rd(8'hD0, rd, rs);
		chk("read", {rs, rd}, 34'h3B);
		axi_rd(8'h10, rd, rs);
		chk("read bad", {rs, rd}, {2'b10, 32'h0});
		core.set_acc(8'h03);
		// bit 0 of the written byte must not stick
		axi_wr(8'hD0, 32'hFFFFFF21, 4'h1, rs);
		chk("write", {rs, 24'h0, status_word_q}, 34'h20);
		axi_wr(8'h14, 32'h0, 4'h1, rs);
		chk("write bad", {rs, 24'h0, status_word_q}, {2'b10, 32'h20});
		axi_wr(8'hD0, 32'h0, 4'h0, rs);
		chk("no strobe", {rs, 24'h0, status_word_q}, 34'h20);
		ex = 8'h20;
		// set every bit singly; parity stays owned by hardware
		for (int i = 0; i < 8; i++) begin
			core.step('0, '{1'b0, 1'b1, 3'(i), 1'b1, 8'h00});
			if (i != 0) ex[i] = 1'b1;
			chk("bit set", status_word_q, ex);
		end
		core.step('{1'b1, PSF_OP_CARRY_SET, 8'h00, 8'h00, 1'b0},
			'{1'b1, 1'b0, 3'd0, 1'b0, 8'h00});
		chk("byte wins", status_word_q, 8'h00);
		core.step('{1'b1, PSF_OP_ADD, 8'hFF, 8'h01, 1'b0},
			'{1'b0, 1'b1, 3'd7, 1'b0, 8'h00});
		chk("bit wins", status_word_q, 8'h40);
		core.set_acc(8'h01);
		chk("parity", status_word_q, 8'h41);
		tally_and_finish();
	end

	// hang guard at 25000 cycles, far beyond the expected 150 or so cycles
	initial begin
		#200000;
		err_total++;
		tally_and_finish();
	end
endmodule

bind psf_program_status_flags psf_status_checker chk_i (.ref_clk, .rst,
	.exec_in, .sfr_wr, .acc_value, .status_word_q, .bank_base_q,
	.s_axi_awvalid, .s_axi_wvalid, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);
